/* sacs_pkg.sv */
// constants, state and result types for the sar adc channel sequencer
package sacs_pkg;
   localparam int SACS_NCH = 8;
   localparam int SACS_CH_W = 3;
   localparam int SACS_RES_W = 12;
   localparam int SACS_SAMP_W = 4;
   localparam int SACS_CNT_W = 5;
   localparam int SACS_DIV_W = 8;
   localparam int SACS_BIT_W = 4;
   localparam int SACS_TCK_W = 6;
   localparam int SACS_FIFO_DEPTH = 8;
   localparam int SACS_SYS_CLK_HZ = 25_000_000;
   localparam int SACS_CONV_CLK_MAX_HZ = 18_000_000;
   localparam int SACS_CONV_DIV_MIN =
      (SACS_SYS_CLK_HZ + SACS_CONV_CLK_MAX_HZ - 1) / SACS_CONV_CLK_MAX_HZ;
   localparam int SACS_CONV_MIN_TICKS = 18;
   localparam int SACS_SAMP_MIN_TICKS = 4;
   localparam int SACS_FINISH_TICKS = 2;

   typedef enum logic [1:0] {
      SACS_IDLE,
      SACS_SAMPLE,
      SACS_CONVERT,
      SACS_FINISH
   } sacs_phase_e;

   typedef struct packed {
      logic [SACS_CH_W-1:0] ch;
      logic [SACS_RES_W-1:0] data;
   } sacs_res_s;

   typedef struct packed {
      sacs_phase_e st;
      logic [SACS_CH_W-1:0] ch;
      logic [SACS_DIV_W-1:0] div;
      logic [SACS_CNT_W-1:0] cnt;
      logic [SACS_BIT_W-1:0] bit_idx;
      logic [SACS_RES_W-1:0] code;
      logic [SACS_NCH-1:0][SACS_RES_W-1:0] res;
      logic oor;
      logic [SACS_RES_W-1:0] rd;
   } sacs_state_s;

   localparam sacs_state_s SACS_STATE_RST = '0;
endpackage

/* sacs_fifo.sv */
// result fifo, flip-flop storage, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sacs_fifo #(
   parameter int W = 15,
   parameter int D = 8
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } sacs_fifo_s;

   sacs_fifo_s q, d;
   logic push, pop;

   assign in_ready_o = (q.cnt != (AW+1)'(D));
   assign out_valid_o = (q.cnt != '0);
   assign out_data_o = q.mem[q.rp];
   assign push = en_i && in_valid_i && in_ready_o;
   assign pop = en_i && out_valid_o && out_ready_i;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wp] = in_data_i;
         d.wp = (q.wp == AW'(D-1)) ? '0 : AW'(q.wp + 1'b1);
      end
      if (pop) begin
         d.rp = (q.rp == AW'(D-1)) ? '0 : AW'(q.rp + 1'b1);
      end
      if (push && !pop) begin
         d.cnt = (AW+1)'(q.cnt + 1'b1);
      end else if (pop && !push) begin
         d.cnt = (AW+1)'(q.cnt - 1'b1);
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= '0;
      end else if (en_i) begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

/* sacs_seq.sv */
// sar adc converter control and 8-input channel sequencer
`timescale 1ns/1ps
`default_nettype none
module sacs_seq
   import sacs_pkg::*;
#(
   parameter int CONV_DIV = SACS_CONV_DIV_MIN,
   parameter int FIFO_DEPTH = SACS_FIFO_DEPTH
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic deep_sleep_i,
   input wire logic scan_mode_i,
   input wire logic [SACS_NCH-1:0] ch_en_i,
   input wire logic fw_start_i,
   input wire logic [SACS_CH_W-1:0] fw_ch_i,
   input wire logic [SACS_NCH-1:0][SACS_SAMP_W-1:0] samp_time_i,
   input wire logic [SACS_RES_W-1:0] lim_lo_i,
   input wire logic [SACS_RES_W-1:0] lim_hi_i,
   input wire logic cmp_i,
   input wire logic oor_clr_i,
   input wire logic [SACS_CH_W-1:0] rd_ch_i,
   input wire logic res_ready_i,
   output logic [SACS_CH_W-1:0] ch_sel_o,
   output logic sample_o,
   output logic [SACS_RES_W-1:0] dac_code_o,
   output logic busy_o,
   output logic oor_o,
   output logic [SACS_RES_W-1:0] rd_data_o,
   output logic res_valid_o,
   output sacs_res_s res_o
);
   sacs_state_s q, d;
   logic tick, done, go, fifo_rdy, out_rng;
   logic [SACS_CH_W-1:0] start_ch;
   sacs_res_s push_word;

   // next enabled channel after cur, wrapping; cur itself comes last
   function automatic logic [SACS_CH_W-1:0] sacs_next_ch(
      input logic [SACS_NCH-1:0] en,
      input logic [SACS_CH_W-1:0] cur);
      logic [SACS_CH_W-1:0] r;
      logic [SACS_CH_W-1:0] c;
      logic found;
      r = cur;
      found = 1'b0;
      for (int k = 1; k <= SACS_NCH; k++) begin
         c = SACS_CH_W'(int'(cur) + k);
         if (!found && en[c]) begin
            r = c;
            found = 1'b1;
         end
      end
      return r;
   endfunction

   // sample window length for a channel, minus one for the down-counter
   function automatic logic [SACS_CNT_W-1:0] sacs_samp_load(
      input logic [SACS_SAMP_W-1:0] st);
      return SACS_CNT_W'(SACS_SAMP_MIN_TICKS - 1) + SACS_CNT_W'(st);
   endfunction

   assign tick = (q.div == SACS_DIV_W'(CONV_DIV - 1));
   assign out_rng = (q.code < lim_lo_i) || (q.code > lim_hi_i);
   assign start_ch = scan_mode_i ? sacs_next_ch(ch_en_i, q.ch) : fw_ch_i;
   assign go = scan_mode_i ? (|ch_en_i) : fw_start_i;
   assign done = en_i && !deep_sleep_i && tick && (q.st == SACS_FINISH)
                 && (q.cnt == '0) && fifo_rdy;
   assign push_word = '{ch: q.ch, data: q.code};

   always_comb begin
      d = q;
      d.rd = q.res[rd_ch_i];
      d.div = tick ? '0 : SACS_DIV_W'(q.div + 1'b1);
      // clear first so a same-cycle range event below wins
      if (oor_clr_i) begin
         d.oor = 1'b0;
      end
      if (deep_sleep_i) begin
         d.st = SACS_IDLE;
      end else begin
         case (q.st)
            SACS_IDLE: begin
               if (go) begin
                  d.st = SACS_SAMPLE;
                  d.ch = start_ch;
                  d.cnt = sacs_samp_load(samp_time_i[start_ch]);
               end
            end
            SACS_SAMPLE: begin
               if (tick) begin
                  if (q.cnt == '0) begin
                     d.st = SACS_CONVERT;
                     d.bit_idx = SACS_BIT_W'(SACS_RES_W - 1);
                     d.code = '0;
                     d.code[SACS_RES_W-1] = 1'b1;
                  end else begin
                     d.cnt = SACS_CNT_W'(q.cnt - 1'b1);
                  end
               end
            end
            SACS_CONVERT: begin
               if (tick) begin
                  // cmp_i high means the input is at or above the trial code
                  if (!cmp_i) begin
                     d.code[q.bit_idx] = 1'b0;
                  end
                  if (q.bit_idx == '0) begin
                     d.st = SACS_FINISH;
                     d.cnt = SACS_CNT_W'(SACS_FINISH_TICKS - 1);
                  end else begin
                     d.code[q.bit_idx - 1'b1] = 1'b1;
                     d.bit_idx = SACS_BIT_W'(q.bit_idx - 1'b1);
                  end
               end
            end
            SACS_FINISH: begin
               // a full fifo holds the result here; back-pressure stalls the scan
               if (tick && q.cnt != '0) begin
                  d.cnt = SACS_CNT_W'(q.cnt - 1'b1);
               end else if (done) begin
                  d.res[q.ch] = q.code;
                  if (out_rng) begin
                     d.oor = 1'b1;
                  end
                  if (scan_mode_i && (|ch_en_i)) begin
                     d.st = SACS_SAMPLE;
                     d.ch = sacs_next_ch(ch_en_i, q.ch);
                     d.cnt = sacs_samp_load(samp_time_i[sacs_next_ch(ch_en_i, q.ch)]);
                  end else begin
                     d.st = SACS_IDLE;
                  end
               end
            end
            default: d.st = SACS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= SACS_STATE_RST;
      end else if (en_i) begin
         q <= d;
      end
   end

   sacs_fifo #(
      .W($bits(sacs_res_s)),
      .D(FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .en_i(en_i),
      .in_valid_i(done),
      .in_ready_o(fifo_rdy),
      .in_data_i(push_word),
      .out_valid_o(res_valid_o),
      .out_ready_i(res_ready_i),
      .out_data_o(res_o)
   );

   assign ch_sel_o = q.ch;
   assign sample_o = (q.st == SACS_SAMPLE);
   assign dac_code_o = q.code;
   assign busy_o = (q.st != SACS_IDLE);
   assign oor_o = q.oor;
   assign rd_data_o = q.rd;

   // helper counters read only by the checks below
   logic [SACS_TCK_W-1:0] conv_ticks_q, samp_ticks_q;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         conv_ticks_q <= '0;
         samp_ticks_q <= '0;
      end else if (en_i) begin
         if (done || q.st == SACS_IDLE) begin
            conv_ticks_q <= '0;
         end else if (tick && conv_ticks_q != '1) begin
            // saturate, so a long fifo stall cannot wrap the count below the minimum
            conv_ticks_q <= SACS_TCK_W'(conv_ticks_q + 1'b1);
         end
         if (q.st != SACS_SAMPLE) begin
            samp_ticks_q <= '0;
         end else if (tick) begin
            samp_ticks_q <= SACS_TCK_W'(samp_ticks_q + 1'b1);
         end
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   sequence s_sample_end;
      en_i && tick && !deep_sleep_i && sample_o && q.cnt == '0;
   endsequence

   tick_rate_a: assert property (en_i && tick |=> !tick)
      else $error("conversion tick faster than allowed");
   conv_len_a: assert property (done |-> conv_ticks_q >= SACS_TCK_W'(SACS_CONV_MIN_TICKS - 1))
      else $error("conversion shorter than minimum");
   samp_len_a: assert property (s_sample_end |->
      samp_ticks_q + 1'b1 == SACS_TCK_W'(SACS_SAMP_MIN_TICKS) + SACS_TCK_W'(samp_time_i[q.ch]))
      else $error("sample window length wrong");
   ch_hold_a: assert property (busy_o && $past(busy_o) && !$past(done) |-> $stable(ch_sel_o))
      else $error("channel changed during conversion");
   scan_gap_a: assert property (done && scan_mode_i && (|ch_en_i) |=> sample_o && ch_en_i[ch_sel_o])
      else $error("scan left a gap between channels");
   fw_start_a: assert property (en_i && !busy_o && !deep_sleep_i && !scan_mode_i && fw_start_i
      |=> sample_o && ch_sel_o == $past(fw_ch_i))
      else $error("firmware start not honoured");
   res_store_a: assert property (done |=> q.res[$past(q.ch)] == $past(q.code))
      else $error("result not stored for channel");
   oor_set_a: assert property (done && out_rng |=> oor_o)
      else $error("range violation not flagged");
   oor_hold_a: assert property (oor_o && !oor_clr_i |=> oor_o)
      else $error("range flag dropped without clear");
   sleep_idle_a: assert property (en_i && deep_sleep_i |=> !busy_o ##1 !busy_o || !deep_sleep_i)
      else $error("sequencer active in deep sleep");
endmodule
`default_nettype wire

/* sacs_ain_model.sv */
// analog pin and sample-and-hold model that answers the converter's comparator
`timescale 1ns/1ps
`default_nettype none
module sacs_ain_model
   import sacs_pkg::*;
(
   input wire logic clock_i,
   input wire logic sample_i,
   input wire logic [SACS_CH_W-1:0] ch_i,
   input wire logic [SACS_RES_W-1:0] dac_i,
   input wire logic [SACS_NCH-1:0][SACS_RES_W-1:0] lvl_i,
   output logic cmp_o
);
   logic [SACS_RES_W-1:0] held_q;
   // the cap follows the routed pin only while sampling, then holds
   always_ff @(posedge clock_i) if (sample_i) held_q <= lvl_i[ch_i];
   // ideal comparator, so a correct search lands exactly on the held level
   assign cmp_o = (held_q >= dac_i);
endmodule
`default_nettype wire

/* sacs_seq_tb.sv */
// self-checking bench for the sar adc channel sequencer
`timescale 1ns/1ps
`default_nettype none
module sacs_seq_tb
   import sacs_pkg::*;
;
   logic clk, nrst, en, ds, scan, fws, clr, rdy, cmp, smp, busy, oor, rv, e;
   logic [31:0] w;
   logic [SACS_NCH-1:0] chen;
   logic [SACS_CH_W-1:0] fwch, rdch, chsel, p;
   logic [SACS_NCH-1:0][SACS_SAMP_W-1:0] st;
   logic [SACS_NCH-1:0][SACS_RES_W-1:0] lvl;
   logic [SACS_RES_W-1:0] lo, hi, dac, rdd;
   sacs_res_s res;
   int miscompares, compares, ns, nb, n, gap, sw;
   sacs_seq dut (.clock_i(clk), .nrst_i(nrst), .en_i(en), .deep_sleep_i(ds),
      .scan_mode_i(scan), .ch_en_i(chen), .fw_start_i(fws), .fw_ch_i(fwch),
      .samp_time_i(st), .lim_lo_i(lo), .lim_hi_i(hi), .cmp_i(cmp), .oor_clr_i(clr),
      .rd_ch_i(rdch), .res_ready_i(rdy), .ch_sel_o(chsel), .sample_o(smp),
      .dac_code_o(dac), .busy_o(busy), .oor_o(oor), .rd_data_o(rdd),
      .res_valid_o(rv), .res_o(res));
   sacs_ain_model pins (.clock_i(clk), .sample_i(smp), .ch_i(chsel), .dac_i(dac),
      .lvl_i(lvl), .cmp_o(cmp));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tk(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic test_done;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // next enabled channel after p, wrapping
   function automatic logic [2:0] nxt(input logic [7:0] en, input logic [2:0] p);
      logic [2:0] c;
      c = p;
      for (int i = 0; i < 8; i++) begin
         c = c + 3'h1;
         if (en[c]) return c;
      end
      return p;
   endfunction
   // firmware start, then count sampling and busy cycles until idle
   task automatic conv(input logic [2:0] c);
      @(posedge clk);
      fwch <= c;
      fws <= 1'b1;
      tk(1);
      fws <= 1'b0;
      ns = 0;
      nb = 0;
      for (int i = 0; i < 2000 && (nb == 0 || busy); i++) begin
         @(negedge clk);
         ns += smp;
         nb += busy;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #400000;
      miscompares++;
      test_done;
   end
   initial begin
      {nrst, ds, scan, fws, clr, rdy, chen, fwch, rdch, st, lvl, lo, hi} = '0;
      en = 1'b1;
      miscompares = 0;
      compares = 0;
      void'($urandom(32'h3bf0));
      tk(2);
      nrst <= 1'b1;
      for (int c = 0; c < SACS_NCH; c++) begin
         @(posedge clk);
         st <= $urandom;
         lvl[c] <= (c == 0) ? 12'h000 : (c == 7) ? 12'hfff : 12'($urandom);
         lo <= 12'($urandom_range(1, 2047));
         hi <= 12'($urandom_range(2048, 4095));
         clr <= 1'b1;
         tk(1);
         clr <= 1'b0;
         conv(3'(c));
         e = lvl[c] < lo || lvl[c] > hi;
         sw = SACS_CONV_DIV_MIN * (SACS_SAMP_MIN_TICKS + st[c]);
         chk(ns >= sw - 1 && ns <= sw, 1);
         chk(nb >= 2 * (SACS_CONV_MIN_TICKS + st[c]) - 1, 1);
         chk(oor, e);
         for (int i = 0; i < 20 && rv !== 1'b1; i++) @(negedge clk);
         chk(res, {3'(c), lvl[c]});
         @(posedge clk);
         rdy <= 1'b1;
         rdch <= 3'(c);
         tk(1);
         rdy <= 1'b0;
         tk(2);
         @(negedge clk);
         chk(rdd, lvl[c]);
         chk(oor, e);
         @(posedge clk);
         clr <= 1'b1;
         tk(1);
         clr <= 1'b0;
         @(negedge clk);
         chk(oor, 0);
      end
      $display("test firmware done");
      @(posedge clk);
      chen <= 8'hff;
      ds <= 1'b1;
      conv(3'h2);
      chk(nb, 0);
      @(posedge clk);
      ds <= 1'b0;
      conv(3'h1);
      chk(nb > 0, 1);
      @(posedge clk);
      // a start then sleep in mid-conversion must drop to idle
      fws <= 1'b1;
      tk(1);
      fws <= 1'b0;
      tk(10);
      ds <= 1'b1;
      tk(2);
      @(negedge clk);
      chk(busy, 0);
      @(posedge clk);
      ds <= 1'b0;
      rdy <= 1'b1;
      tk(20);
      $display("test sleep done");
      // a range event in the same cycle as a held clear leaves the flag set
      clr <= 1'b1;
      conv(3'h0);
      chk(oor, 1);
      @(posedge clk);
      clr <= 1'b0;
      // clock enable low freezes a conversion mid-flight, which then completes intact
      fwch <= 3'h3;
      rdch <= 3'h3;
      fws <= 1'b1;
      tk(1);
      fws <= 1'b0;
      tk(20);
      en <= 1'b0;
      tk(1);
      @(negedge clk);
      w = {busy, smp, chsel, dac};
      tk(12);
      @(negedge clk);
      chk({busy, smp, chsel, dac}, w);
      chk(busy, 1);
      @(posedge clk);
      en <= 1'b1;
      for (int i = 0; i < 200 && busy; i++) @(negedge clk);
      tk(2);
      @(negedge clk);
      chk(rdd, lvl[3]);
      @(posedge clk);
      $display("test enable done");
      chen <= 8'($urandom) | 8'h21;
      st <= $urandom;
      lvl <= {$urandom, $urandom, $urandom};
      scan <= 1'b1;
      n = 0;
      gap = 0;
      for (int i = 0; i < 3000 && n < 12; i++) begin
         @(negedge clk);
         if (n > 0 && !busy) gap++;
         if (rv) begin
            if (n > 0) chk(res.ch, nxt(chen, p));
            chk(chen[res.ch], 1);
            chk(res.data, lvl[res.ch]);
            p = res.ch;
            n++;
         end
      end
      chk(gap, 0);
      chk(n, 12);
      @(posedge clk);
      scan <= 1'b0;
      tk(200);
      $display("test scan done");
      // fifo fills while firmware stalls, then one more waits in the sequencer
      rdy <= 1'b0;
      st <= '0;
      scan <= 1'b1;
      tk(500);
      scan <= 1'b0;
      tk(100);
      rdy <= 1'b1;
      n = 0;
      repeat (200) begin
         @(negedge clk);
         n += rv;
      end
      chk(n, SACS_FIFO_DEPTH + 1);
      $display("test fifo done");
      test_done;
   end
endmodule
`default_nettype wire
